// ---- inc/brmsr_consts.vh ----
`ifndef BRMSR_CONSTS_VH
`define BRMSR_CONSTS_VH
// Register indices; byte address is eight times the index, upper half at index*8+4.
`define BRMSR_IDX_MISC_ENABLE   12'h1A0
`define BRMSR_IDX_STACK_TOP     12'h1C9
`define BRMSR_IDX_DEBUG_CTL     12'h1D9
`define BRMSR_IDX_EXC_TARGET    12'h1DD
`define BRMSR_IDX_EXC_SOURCE    12'h1DE
`define BRMSR_IDX_MEM_TYPE      12'h2FF
`define BRMSR_IDX_ERR0_CTL      12'h400
`define BRMSR_IDX_ERR0_STATUS   12'h401
`define BRMSR_IDX_ERR0_ADDR     12'h402
`define BRMSR_IDX_IRQ_STATUS    12'h7F0
`define BRMSR_IDX_IRQ_MASK      12'h7F1
`define BRMSR_IDX_FAULT_INFO    12'h7F2
// Field positions.
`define BRMSR_BIT_DVFS_EN       16
`define BRMSR_BIT_TPR_DIS       23
`define BRMSR_BIT_ADDR_VALID    58
`define BRMSR_TOP_W             4
// Reset values and the write mask of the misc register.
`define BRMSR_RST_MISC          64'h0000000000010000
`define BRMSR_RST_ZERO          64'h0000000000000000
`define BRMSR_MISC_WMASK        64'h0000000000810000
// Interrupt status bits.
`define BRMSR_IRQ_GP            0
`define BRMSR_IRQ_BRANCH        1
`define BRMSR_IRQ_ERROR         2
`define BRMSR_IRQ_W             3
`endif

// ---- verilog/brmsr_bank.v ----
`include "brmsr_consts.vh"
`default_nettype none
module brmsr_bank #(
    parameter       DVFS_LOCK      = 0,
    parameter       TPR_DIS_RESET  = 0,
    parameter       ERR_ADDR_IMPL  = 1
) (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // Avalon-MM slave, byte address.
    input  wire [13:0] avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Core events.
    input  wire        branch_rec_i,
    input  wire [3:0]  branch_slot_i,
    input  wire [63:0] branch_source_i,
    input  wire [63:0] branch_target_i,
    input  wire        exception_i,
    input  wire        error_log_i,
    input  wire [63:0] error_status_i,
    input  wire [63:0] error_addr_i,
    // Outputs to the core.
    output wire        dvfs_enable_o,
    output wire        tpr_msg_enable_o,
    output wire [63:0] debug_ctl_o,
    output wire [63:0] mem_type_o,
    output wire [63:0] err_ctl_o,
    output reg         gp_fault_o,
    output wire        irq_o
);
    reg  [63:0] misc_ff;
    reg  [3:0]  top_ff;
    reg  [63:0] dbg_ff;
    reg  [63:0] last_src_ff;
    reg  [63:0] last_tgt_ff;
    reg  [63:0] exc_src_ff;
    reg  [63:0] exc_tgt_ff;
    reg  [63:0] mtype_ff;
    reg  [63:0] ectl_ff;
    reg  [63:0] estat_ff;
    reg  [63:0] eaddr_ff;
    reg  [2:0]  irq_st_ff;
    reg  [2:0]  irq_mk_ff;
    reg  [11:0] fault_idx_ff;
    reg         ack_ff;
    reg  [63:0] rd_val;
    reg         hit;
    reg  [31:0] wmask;
    reg  [63:0] nxt_wdata;
    reg  [63:0] nxt_wmask;
    reg  [2:0]  nxt_irq_st;
    wire        hi   = avs_address_i[2];
    wire        req  = avs_read_i | avs_write_i;
    wire        gp_ev;
    wire        wr;
    wire [11:0] reg_idx;
    assign reg_idx = {1'b0, avs_address_i[13:3]};
    // Each register takes two words: index*8 low half, index*8+4 high half.
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr                = avs_write_i & ack_ff & hit;
    assign gp_ev             = req & ack_ff & ~hit;
    assign dvfs_enable_o     = misc_ff[`BRMSR_BIT_DVFS_EN];
    assign tpr_msg_enable_o  = ~misc_ff[`BRMSR_BIT_TPR_DIS];
    assign debug_ctl_o       = dbg_ff;
    assign mem_type_o        = mtype_ff;
    assign err_ctl_o         = ectl_ff;
    assign irq_o             = |(irq_st_ff & irq_mk_ff);

    always @* begin
        hit   = 1'b1;
        rd_val = `BRMSR_RST_ZERO;
        case (reg_idx)
            `BRMSR_IDX_MISC_ENABLE:  rd_val = misc_ff;
            `BRMSR_IDX_STACK_TOP:    rd_val = {60'h000000000000000, top_ff};
            `BRMSR_IDX_DEBUG_CTL:    rd_val = dbg_ff;
            `BRMSR_IDX_EXC_TARGET:   rd_val = exc_tgt_ff;
            `BRMSR_IDX_EXC_SOURCE:   rd_val = exc_src_ff;
            `BRMSR_IDX_MEM_TYPE:     rd_val = mtype_ff;
            `BRMSR_IDX_ERR0_CTL:     rd_val = ectl_ff;
            `BRMSR_IDX_ERR0_STATUS:  rd_val = estat_ff;
            `BRMSR_IDX_ERR0_ADDR: begin
                hit    = (ERR_ADDR_IMPL != 0);
                rd_val = estat_ff[`BRMSR_BIT_ADDR_VALID] ? eaddr_ff : `BRMSR_RST_ZERO;
            end
            `BRMSR_IDX_IRQ_STATUS:   rd_val = {61'h0, irq_st_ff};
            `BRMSR_IDX_IRQ_MASK:     rd_val = {61'h0, irq_mk_ff};
            `BRMSR_IDX_FAULT_INFO:   rd_val = {52'h0, fault_idx_ff};
            default:                 hit = 1'b0;
        endcase
    end

    always @* begin
        wmask     = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        nxt_wdata = hi ? {avs_writedata_i, 32'h00000000} : {32'h00000000, avs_writedata_i};
        nxt_wmask = hi ? {wmask, 32'h00000000} : {32'h00000000, wmask};
    end

    always @* begin
        nxt_irq_st = irq_st_ff;
        if (wr && reg_idx == `BRMSR_IDX_IRQ_STATUS && !hi)
            nxt_irq_st = irq_st_ff & ~(avs_writedata_i[2:0] & wmask[2:0]);
        if (gp_ev)
            nxt_irq_st[`BRMSR_IRQ_GP] = 1'b1;
        if (branch_rec_i)
            nxt_irq_st[`BRMSR_IRQ_BRANCH] = 1'b1;
        if (error_log_i)
            nxt_irq_st[`BRMSR_IRQ_ERROR] = 1'b1;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff         <= 1'b0;
            avs_readdata_o <= 32'h00000000;
            gp_fault_o     <= 1'b0;
            fault_idx_ff   <= 12'h000;
            misc_ff        <= `BRMSR_RST_MISC;
            misc_ff[`BRMSR_BIT_TPR_DIS] <= (TPR_DIS_RESET != 0);
            top_ff         <= 4'h0;
            dbg_ff         <= `BRMSR_RST_ZERO;
            last_src_ff    <= `BRMSR_RST_ZERO;
            last_tgt_ff    <= `BRMSR_RST_ZERO;
            exc_src_ff     <= `BRMSR_RST_ZERO;
            exc_tgt_ff     <= `BRMSR_RST_ZERO;
            mtype_ff       <= `BRMSR_RST_ZERO;
            ectl_ff        <= `BRMSR_RST_ZERO;
            estat_ff       <= `BRMSR_RST_ZERO;
            eaddr_ff       <= `BRMSR_RST_ZERO;
            irq_st_ff      <= 3'h0;
            irq_mk_ff      <= 3'h0;
        end else begin
            ack_ff     <= req & ~ack_ff;
            gp_fault_o <= gp_ev;
            irq_st_ff  <= nxt_irq_st;
            if (req && !ack_ff)
                avs_readdata_o <= hi ? rd_val[63:32] : rd_val[31:0];
            if (gp_ev)
                fault_idx_ff <= reg_idx;
            // Branch recording follows the core; an exception copies the last pair, or the branch of the same cycle, into the exception pair.
            if (branch_rec_i) begin
                top_ff      <= branch_slot_i;
                last_src_ff <= branch_source_i;
                last_tgt_ff <= branch_target_i;
            end
            if (exception_i) begin
                exc_tgt_ff <= branch_rec_i ? branch_target_i : last_tgt_ff;
                exc_src_ff <= branch_rec_i ? branch_source_i : last_src_ff;
            end
            if (error_log_i) begin
                estat_ff <= error_status_i;
                eaddr_ff <= (ERR_ADDR_IMPL != 0) ? error_addr_i : `BRMSR_RST_ZERO;
            end
            if (wr) begin
                case (reg_idx)
                    `BRMSR_IDX_MISC_ENABLE: begin
                        // Only the two feature bits are writable; the rest reads zero.
                        misc_ff <= (misc_ff & ~(nxt_wmask & `BRMSR_MISC_WMASK))
                                 | (nxt_wdata & nxt_wmask & `BRMSR_MISC_WMASK);
                        if (DVFS_LOCK != 0)
                            misc_ff[`BRMSR_BIT_DVFS_EN] <= misc_ff[`BRMSR_BIT_DVFS_EN];
                    end
                    `BRMSR_IDX_DEBUG_CTL:
                        dbg_ff <= (dbg_ff & ~nxt_wmask) | (nxt_wdata & nxt_wmask);
                    `BRMSR_IDX_MEM_TYPE:
                        mtype_ff <= (mtype_ff & ~nxt_wmask) | (nxt_wdata & nxt_wmask);
                    `BRMSR_IDX_ERR0_CTL:
                        ectl_ff <= (ectl_ff & ~nxt_wmask) | (nxt_wdata & nxt_wmask);
                    `BRMSR_IDX_ERR0_STATUS:
                        if (!error_log_i)
                            estat_ff <= (estat_ff & ~nxt_wmask) | (nxt_wdata & nxt_wmask);
                    `BRMSR_IDX_ERR0_ADDR:
                        if (!error_log_i)
                            eaddr_ff <= (eaddr_ff & ~nxt_wmask) | (nxt_wdata & nxt_wmask);
                    `BRMSR_IDX_IRQ_MASK:
                        if (!hi)
                            irq_mk_ff <= (irq_mk_ff & ~wmask[2:0])
                                       | (avs_writedata_i[2:0] & wmask[2:0]);
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule // brmsr_bank
`default_nettype wire

// ---- tb/brmsr_bank_sva.sv ----
`default_nettype none
module brmsr_bank_sva #(parameter TPR_DIS_RESET = 0) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [13:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        dvfs_enable_o,
    input wire logic        tpr_msg_enable_o,
    input wire logic [63:0] debug_ctl_o,
    input wire logic [63:0] mem_type_o,
    input wire logic        gp_fault_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
wire        req = avs_read_i | avs_write_i;
wire        rd_ok = avs_read_i & ~avs_waitrequest_o;
wire        wr_ok = avs_write_i & ~avs_waitrequest_o;
wire [10:0] idx = avs_address_i[13:3];
wire        w_misc = wr_ok && idx == 11'h1A0 && !avs_address_i[2];
property p_wait; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
a_wait: assert property (p_wait) else $error("wait not one cycle");
property p_dvfs; $changed(dvfs_enable_o) |-> $past(w_misc); endproperty
a_dvfs: assert property (p_dvfs) else $error("scaling enable moved");
property p_tpr; $changed(tpr_msg_enable_o) |-> $past(w_misc); endproperty
a_tpr: assert property (p_tpr) else $error("priority message moved");
property p_dbg; $changed(debug_ctl_o) |-> $past(wr_ok && idx == 11'h1D9); endproperty
a_dbg: assert property (p_dbg) else $error("debug control moved");
property p_mem; $changed(mem_type_o) |-> $past(wr_ok && idx == 11'h2FF); endproperty
a_mem: assert property (p_mem) else $error("memory type moved");
property p_gp; rd_ok && idx == 11'h123 |=> gp_fault_o; endproperty
a_gp: assert property (p_gp) else $error("no fault on unmapped read");
property p_gp1; gp_fault_o |=> !gp_fault_o; endproperty
a_gp1: assert property (p_gp1) else $error("fault pulse too long");
property p_rst; $fell(rst_i) |-> tpr_msg_enable_o == !TPR_DIS_RESET; endproperty
a_rst: assert property (p_rst) else $error("priority message reset value");
cover property (w_misc);
cover property (gp_fault_o);
cover property (rd_ok && idx == 11'h1DD);
endmodule // brmsr_bank_sva
bind brmsr_bank brmsr_bank_sva #(.TPR_DIS_RESET(TPR_DIS_RESET)) sva_u (.clk_i(clk_i),
    .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .dvfs_enable_o(dvfs_enable_o), .tpr_msg_enable_o(tpr_msg_enable_o),
    .debug_ctl_o(debug_ctl_o), .mem_type_o(mem_type_o), .gp_fault_o(gp_fault_o));
`default_nettype wire

// ---- tb/brmsr_bank_tb.sv ----
`default_nettype none
module brmsr_bank_tb;
timeunit 1ns;
timeprecision 1ns;
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
logic        clk_i = 1'b0;
logic        rst_i = 1'b1;
logic [13:0] adr = 14'h0;
logic        rd = 1'b0;
logic        wr = 1'b0;
logic        br = 1'b0;
logic        exc = 1'b0;
logic        elog = 1'b0;
logic [3:0]  slot = 4'h0;
logic [31:0] wd = 32'h0;
logic [63:0] src = 64'h0;
logic [63:0] tgt = 64'h0;
logic [63:0] est = 64'h0;
logic [63:0] ead = 64'h0;
logic [31:0] rdat, q, rdat2, q2;
logic [63:0] dbg, mem;
logic        wq, dvfs, tpr, gp, irq, dvfs2, gp2;
localparam int TPR_RST = 1;
int          n_errors = 0;
int          checks = 0;
int          n_gp = 0;
int          n_gp2 = 0;
brmsr_bank #(.TPR_DIS_RESET(TPR_RST)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .branch_rec_i(br), .branch_slot_i(slot), .branch_source_i(src),
    .branch_target_i(tgt), .exception_i(exc), .error_log_i(elog), .error_status_i(est),
    .error_addr_i(ead), .dvfs_enable_o(dvfs), .tpr_msg_enable_o(tpr), .debug_ctl_o(dbg),
    .mem_type_o(mem), .err_ctl_o(), .gp_fault_o(gp), .irq_o(irq));
// A second instance with the scaling bit locked and no error address register.
brmsr_bank #(.DVFS_LOCK(1), .ERR_ADDR_IMPL(0)) dut2_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat2), .avs_waitrequest_o(),
    .branch_rec_i(br), .branch_slot_i(slot), .branch_source_i(src),
    .branch_target_i(tgt), .exception_i(exc), .error_log_i(elog), .error_status_i(est),
    .error_addr_i(ead), .dvfs_enable_o(dvfs2), .tpr_msg_enable_o(), .debug_ctl_o(),
    .mem_type_o(), .err_ctl_o(), .gp_fault_o(gp2), .irq_o());
always #10 clk_i = ~clk_i;
always @(posedge clk_i) begin
    if (gp === 1'b1) n_gp <= n_gp + 1;
    if (gp2 === 1'b1) n_gp2 <= n_gp2 + 1;
end
task automatic acc(input logic w, input logic [10:0] ix, input logic h, input logic [31:0] d);
    adr <= {ix, h, 2'b00};
    wd <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk_i);
    while (wq !== 1'b0) @(posedge clk_i);
    q = rdat;
    q2 = rdat2;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
endtask
task automatic pulse(input logic b, input logic e, input logic l);
    br <= b;
    exc <= e;
    elog <= l;
    @(posedge clk_i);
    br <= 1'b0;
    exc <= 1'b0;
    elog <= 1'b0;
    @(posedge clk_i);
endtask
task automatic test_done;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task automatic t_misc;
    acc(1'b0, 11'h1A0, 1'b0, 32'h0);
    `CK("misc", 32'h00010000 | (TPR_RST << 23), q)
    `CK("tpr", TPR_RST == 0, tpr)
    acc(1'b1, 11'h1A0, 1'b0, 32'hFFFFFFFF);
    acc(1'b0, 11'h1A0, 1'b0, 32'h0);
    `CK("misc", 32'h00810000, q)
    `CK("tpr", 1'b0, tpr)
    acc(1'b1, 11'h1A0, 1'b0, 32'h0);
    `CK("dvfs", 1'b0, dvfs)
    `CK("tpr", 1'b1, tpr)
    `CK("dvfs_lock", 1'b1, dvfs2)
    acc(1'b0, 11'h1A0, 1'b1, 32'h0);
    `CK("misc_hi", 32'h0, q)
endtask
task automatic t_rw;
    for (int i = 0; i < 4; i++) begin
        acc(1'b1, i[1] ? 11'h2FF : 11'h1D9, i[0], 32'h5A000000 | i);
        acc(1'b0, i[1] ? 11'h2FF : 11'h1D9, i[0], 32'h0);
        `CK("rw", 32'h5A000000 | i, q)
    end
    `CK("dbg", 64'h5A0000015A000000, dbg)
    `CK("mem", 64'h5A0000035A000002, mem)
endtask
task automatic t_branch;
    slot <= 4'hB;
    src <= 64'h11;
    tgt <= 64'h22;
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b1, 1'b0);
    slot <= 4'hC;
    src <= 64'h33;
    pulse(1'b1, 1'b0, 1'b0);
    acc(1'b0, 11'h1C9, 1'b0, 32'h0);
    `CK("top", 4'hC, q[3:0])
    acc(1'b0, 11'h1DD, 1'b0, 32'h0);
    `CK("target", 32'h22, q)
    acc(1'b0, 11'h1DE, 1'b0, 32'h0);
    `CK("source", 32'h11, q)
    src <= 64'h44;
    tgt <= 64'h55;
    pulse(1'b1, 1'b1, 1'b0);
    acc(1'b0, 11'h1DD, 1'b0, 32'h0);
    `CK("target_same", 32'h55, q)
    acc(1'b0, 11'h1DE, 1'b0, 32'h0);
    `CK("source_same", 32'h44, q)
endtask
task automatic t_err;
    ead <= 64'h00000000DEAD0000;
    pulse(1'b0, 1'b0, 1'b1);
    acc(1'b0, 11'h402, 1'b0, 32'h0);
    `CK("addr", 32'h0, q)
    est <= 64'h0400000000000000;
    ead <= 64'h00000000CAFE0040;
    pulse(1'b0, 1'b0, 1'b1);
    acc(1'b0, 11'h402, 1'b0, 32'h0);
    `CK("addr", 32'hCAFE0040, q)
    `CK("addr2", 32'h0, q2)
    acc(1'b0, 11'h7F2, 1'b0, 32'h0);
    `CK("fault2", 32'h402, q2)
    `CK("gp2", 2, n_gp2)
    `CK("gp", 0, n_gp)
endtask
task automatic t_gp;
    acc(1'b0, 11'h123, 1'b0, 32'h0);
    `CK("unmapped", 32'h0, q)
    `CK("irq", 1'b0, irq)
    acc(1'b0, 11'h7F2, 1'b0, 32'h0);
    `CK("fault", 32'h123, q)
    `CK("gp", 1, n_gp)
    acc(1'b0, 11'h7F0, 1'b0, 32'h0);
    `CK("status", 32'h7, q)
    acc(1'b1, 11'h7F1, 1'b0, 32'h1);
    `CK("irq", 1'b1, irq)
    acc(1'b1, 11'h7F0, 1'b0, 32'h1);
    `CK("irq", 1'b0, irq)
endtask
initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_misc();
    t_rw();
    t_branch();
    t_err();
    t_gp();
    test_done();
end
initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    test_done();
end
endmodule // brmsr_bank_tb
`default_nettype wire
